// ### core/ies_pkg.sv
// constants and types for the interrupt entry sequencer
// Notes on behaviour
// - ack cycle T1 status: ack and fetch set
// - ack cycle follows last period of instruction
// - one byte taken into instruction register
// - accept enable drops in ack T1
// - pc on address bus, not incremented
// - memory read status off in ack
// - far end drives opcode for T3 capture
// - vector call goes to vector times eight
// - vector call: sp down, two pushes, jump
// - inserted call never bumps pc in T2
// - call address bytes fetched by null cycles
// - far end gives low then high byte
// - push pc high then low, fetch target
// - far end never inserts stack swap
// - no acknowledge during hold, or during wait unless halted
// - ready low stretches the cycle
// - request leaves halt; hold blocks it
// - halted ack shows halted status, pc held
// - 64K memory space, separate io space
// - status byte each T1: D7 read, D1 write
// - status D6 input, D4 output
// - far end drops request before re-enable
package ies_pkg;
   // ------------------------------------------------------------
   // status bit positions
   // ------------------------------------------------------------
   localparam int ST_ACK   = 0;
   localparam int ST_WLOW  = 1;
   localparam int ST_HALT  = 3;
   localparam int ST_OUT   = 4;
   localparam int ST_FETCH = 5;
   localparam int ST_IN    = 6;
   localparam int ST_MRD   = 7;
   // ------------------------------------------------------------
   // opcodes and widths
   // ------------------------------------------------------------
   localparam int          AW         = 16;
   localparam logic [7:0]  OP_CALL    = 8'hcd;
   localparam logic [7:0]  VEC_MASK   = 8'hc7;
   localparam logic [7:0]  VEC_CODE   = 8'hc7;
   localparam logic [7:0]  OP_SWAP    = 8'he3;
   localparam logic [7:0]  OP_NOP     = 8'h00;
   localparam logic [15:0] SP_RESET   = 16'h0000;
   localparam logic [15:0] PC_RESET   = 16'h0000;
   // cycle kinds seen by the far end
   typedef enum logic [2:0] {
      IES_CY_IDLE  = 3'b000,
      IES_CY_ACK   = 3'b001,
      IES_CY_NULL  = 3'b010,
      IES_CY_PUSH  = 3'b011,
      IES_CY_FETCH = 3'b100
   } ies_cycle_e;
endpackage

// ### core/ies_bus_if.sv
// link between the sequencer and the external interrupt logic
`timescale 1ns/100ps
interface ies_bus_if;
   logic       service_req;
   logic       accept_enable_out;
   logic       t1_strobe;
   logic       t3_strobe;
   logic [7:0] status_byte;
   logic [15:0] addr;
   logic [7:0] data_to_cpu;
   logic [7:0] data_from_cpu;
   logic       ready;
   logic       hold;
   modport cpu (input service_req, data_to_cpu, ready, hold,
                output accept_enable_out, t1_strobe, t3_strobe,
                status_byte, addr, data_from_cpu);
   modport ext (output service_req, data_to_cpu, ready, hold,
                input accept_enable_out, t1_strobe, t3_strobe,
                status_byte, addr, data_from_cpu);
endinterface

// ### core/ies_cpu_end.sv
// sequencer end: acknowledge cycle and inserted instruction
`timescale 1ns/100ps
module ies_cpu_end
   import ies_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        arst_n,
   // link
   ies_bus_if.cpu           bus,
   // core side
   input  wire logic        insn_last,
   input  wire logic        irq_enable_insn,
   input  wire logic        halted,
   output logic             seq_busy_ff,
   output logic [15:0]      pc_ff,
   output logic [15:0]      sp_ff,
   output logic [7:0]       ir_ff,
   output logic             halted_ack_status_ff
);
   // ------------------------------------------------------------
   // states: one per clock period; A2, N2 and P2 repeat while ready is low
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE = 4'b0000, S_A1 = 4'b0001, S_A2 = 4'b0010,
      S_A3 = 4'b0011, S_A4 = 4'b0100, S_N1 = 4'b0101,
      S_N2 = 4'b0110, S_N3 = 4'b0111, S_P1 = 4'b1000,
      S_P2 = 4'b1001, S_P3 = 4'b1010, S_JMP = 4'b1011
   } ies_state_e;

   ies_state_e  st_ff, nxt_st;
   logic [1:0]  nidx_ff;
   logic [1:0]  pidx_ff;
   logic        ie_ff;
   logic [7:0]  z_ff;
   logic [7:0]  w_ff;
   logic [7:0]  stat_ff;
   logic        t1_ff;
   logic        t3_ff;
   logic [15:0] addr_ff;
   logic [7:0]  wdata_ff;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire stalled  = bus.hold | ~bus.ready;
   wire take_req = bus.service_req & ie_ff & ~bus.hold
                   & ((insn_last & ~stalled) | halted);
   wire op_vec   = (bus.data_to_cpu & VEC_MASK) == VEC_CODE;
   wire op_call  = bus.data_to_cpu == OP_CALL;
   wire ir_vec   = (ir_ff & VEC_MASK) == VEC_CODE;
   wire ir_call  = ir_ff == OP_CALL;
   wire [15:0] vec_addr = {10'h000, ir_ff[5:3], 3'b000};
   wire [15:0] call_addr = {w_ff, z_ff};
   wire        first_push = st_ff != S_P3;
   wire        go_push    = nxt_st == S_P1;
   wire [7:0]  push_byte = first_push ? pc_ff[15:8]
                                      : pc_ff[7:0];
   wire [15:0] push_addr = (st_ff == S_A4) ? sp_ff - 16'd1
                                           : sp_ff;
   wire [7:0] st_ack  = (8'h01 << ST_ACK) | (8'h01 << ST_FETCH)
                        | (8'h01 << ST_WLOW);
   wire [7:0] st_hack = st_ack | (8'h01 << ST_HALT);
   wire [7:0] st_null = 8'h01 << ST_WLOW;
   wire [7:0] st_push = 8'h00;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      nxt_st = st_ff;
      case (st_ff)
         S_IDLE: if (take_req) nxt_st = S_A1;
         S_A1:   nxt_st = S_A2;
         S_A2:   if (bus.ready) nxt_st = S_A3;
         S_A3:   nxt_st = S_A4;
         S_A4:   nxt_st = ir_call ? S_N1 : ir_vec ? S_P1 : S_IDLE;
         S_N1:   nxt_st = S_N2;
         S_N2:   if (bus.ready) nxt_st = S_N3;
         S_N3:   nxt_st = (nidx_ff == 2'd1) ? S_P1 : S_N1;
         S_P1:   nxt_st = S_P2;
         S_P2:   if (bus.ready) nxt_st = S_P3;
         S_P3:   nxt_st = (pidx_ff == 2'd1) ? S_JMP : S_P1;
         S_JMP:  nxt_st = S_IDLE;
         default: nxt_st = S_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // sequencer registers
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_ff <= S_IDLE;
         nidx_ff <= 2'd0;
         pidx_ff <= 2'd0;
         ie_ff <= 1'b0;
      end
      else
      begin
         st_ff <= nxt_st;
         if (st_ff == S_A1)
            ie_ff <= 1'b0;
         else if (irq_enable_insn && !seq_busy_ff)
            ie_ff <= 1'b1;
         if (st_ff == S_A1)
            nidx_ff <= 2'd0;
         else if (st_ff == S_N3)
            nidx_ff <= nidx_ff + 2'd1;
         if (st_ff == S_A4)
            pidx_ff <= 2'd0;
         else if (st_ff == S_P3)
            pidx_ff <= pidx_ff + 2'd1;
      end
   end

   // ------------------------------------------------------------
   // datapath registers
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pc_ff <= PC_RESET;
         sp_ff <= SP_RESET;
         ir_ff <= OP_NOP;
         z_ff <= 8'h00;
         w_ff <= 8'h00;
      end
      else
      begin
         if (st_ff == S_A3)
            ir_ff <= bus.data_to_cpu;
         if (st_ff == S_A4 && (ir_vec || ir_call))
            sp_ff <= sp_ff - 16'd1;
         if (st_ff == S_P2 && bus.ready && pidx_ff == 2'd0)
            sp_ff <= sp_ff - 16'd1;
         if (st_ff == S_N3 && nidx_ff == 2'd0)
            z_ff <= bus.data_to_cpu;
         if (st_ff == S_N3 && nidx_ff == 2'd1)
            w_ff <= bus.data_to_cpu;
         if (st_ff == S_JMP)
            pc_ff <= ir_call ? call_addr : vec_addr;
      end
   end

   // ------------------------------------------------------------
   // link and core-side outputs, all registered
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stat_ff <= 8'h00;
         t1_ff <= 1'b0;
         t3_ff <= 1'b0;
         seq_busy_ff <= 1'b0;
         halted_ack_status_ff <= 1'b0;
      end
      else
      begin
         t1_ff <= (nxt_st == S_A1) || (nxt_st == S_N1)
                  || (nxt_st == S_P1);
         t3_ff <= (nxt_st == S_A3) || (nxt_st == S_N3);
         seq_busy_ff <= nxt_st != S_IDLE;
         halted_ack_status_ff <= (nxt_st == S_A1) && halted;
         if (nxt_st == S_A1)
            stat_ff <= halted ? st_hack : st_ack;
         else if (nxt_st == S_N1)
            stat_ff <= st_null;
         else if (nxt_st == S_P1)
            stat_ff <= st_push;
      end
   end

   // ------------------------------------------------------------
   // address and stack write data, standing until next T1
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         addr_ff <= 16'h0000;
         wdata_ff <= 8'h00;
      end
      else
      begin
         if (nxt_st == S_A1 || nxt_st == S_N1)
            addr_ff <= pc_ff;
         else if (go_push)
            addr_ff <= push_addr;
         if (go_push)
            wdata_ff <= push_byte;
      end
   end
   // pc is never stepped inside the sequence

   assign bus.accept_enable_out = ie_ff;
   assign bus.status_byte       = stat_ff;
   assign bus.t1_strobe         = t1_ff;
   assign bus.t3_strobe         = t3_ff;
   assign bus.addr              = addr_ff;
   assign bus.data_from_cpu     = wdata_ff;
   wire unused_ok = ^{stalled, op_vec, op_call, st_ff == S_JMP};
endmodule // ies_cpu_end

// ### core/ies_ext_end.sv
// external interrupt logic end: requests and supplies bytes
`timescale 1ns/100ps
module ies_ext_end
   import ies_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        arst_n,
   // link
   ies_bus_if.ext           bus,
   // user side
   input  wire logic        raise_req,
   input  wire logic [7:0]  insn_byte,
   input  wire logic [15:0] target_addr,
   input  wire logic [1:0]  wait_periods,
   input  wire logic        hold_in,
   output logic             req_pending_ff
);
   // ------------------------------------------------------------
   // request and byte sequencing
   // ------------------------------------------------------------
   logic [1:0] byte_idx_ff;
   logic [1:0] wait_ff;
   logic [7:0] data_ff;
   logic       ready_ff;
   logic       hold_ff;
   logic [7:0] lat_stat_ff;

   wire ack_seen  = bus.t1_strobe & bus.status_byte[ST_ACK];
   wire null_seen = bus.t1_strobe & ~bus.status_byte[ST_MRD]
                    & ~bus.status_byte[ST_ACK]
                    & bus.status_byte[ST_WLOW];
   wire byte_ask  = ack_seen | null_seen;
   wire [7:0] safe_op = (insn_byte == OP_SWAP) ? OP_NOP : insn_byte;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         req_pending_ff <= 1'b0;
         byte_idx_ff <= 2'd0;
         wait_ff <= 2'd0;
         data_ff <= 8'h00;
         ready_ff <= 1'b1;
         hold_ff <= 1'b0;
         lat_stat_ff <= 8'h00;
      end
      else
      begin
         hold_ff <= hold_in;
         if (bus.t1_strobe)
            lat_stat_ff <= bus.status_byte;
         if (raise_req)
            req_pending_ff <= 1'b1;
         else if (ack_seen)
            req_pending_ff <= 1'b0;
         if (ack_seen)
         begin
            data_ff <= safe_op;
            byte_idx_ff <= 2'd0;
            wait_ff <= wait_periods;
         end
         else if (null_seen)
         begin
            data_ff <= (byte_idx_ff == 2'd0) ? target_addr[7:0]
                                             : target_addr[15:8];
            byte_idx_ff <= byte_idx_ff + 2'd1;
            wait_ff <= wait_periods;
         end
         else if (wait_ff != 2'd0)
            wait_ff <= wait_ff - 2'd1;
         ready_ff <= !(byte_ask && wait_periods != 2'd0)
                     && !(wait_ff > 2'd1);
      end
   end

   assign bus.service_req = req_pending_ff;
   assign bus.data_to_cpu = data_ff;
   assign bus.ready       = ready_ff;
   assign bus.hold        = hold_ff;
   wire unused_ok = ^{bus.t3_strobe, bus.addr, lat_stat_ff,
                      bus.accept_enable_out, bus.data_from_cpu};
endmodule // ies_ext_end

// ### bench/ies_properties.sv
// link property checker for the interrupt entry sequencer
`timescale 1ns/100ps
module ies_properties
   import ies_pkg::*;
(
   // clock and reset
   input wire logic        clock,
   input wire logic        arst_n,
   // link
   input wire logic        service_req,
   input wire logic        accept_enable_out,
   input wire logic        t1_strobe,
   input wire logic        t3_strobe,
   input wire logic [7:0]  status_byte,
   input wire logic [15:0] addr,
   input wire logic        ready,
   input wire logic        hold
);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   wire ack_t1 = t1_strobe && status_byte[ST_ACK];

   chk_ack_fetch_bit: assert property (ack_t1 |-> status_byte[ST_FETCH])
      else $error("ack cycle without fetch bit");
   chk_take_cause: assert property (
      ack_t1 |-> $past(service_req && accept_enable_out))
      else $error("ack cycle without accepted request");
   chk_take_hold: assert property (ack_t1 |-> !$past(hold))
      else $error("request taken under hold");
   chk_accept_drop: assert property (ack_t1 |=> !accept_enable_out)
      else $error("accept enable still set after ack");
   chk_ack_no_read: assert property (ack_t1 |-> !status_byte[ST_MRD])
      else $error("memory read status in ack cycle");
   chk_t3_follows: assert property (ack_t1 |-> ##[2:8] t3_strobe)
      else $error("no opcode capture after ack");
   chk_t3_ready: assert property (t3_strobe |-> $past(ready))
      else $error("capture while ready low");
   chk_addr_holds: assert property (!t1_strobe |-> $stable(addr))
      else $error("address moved outside cycle start");
   chk_status_holds: assert property (
      !t1_strobe |-> $stable(status_byte))
      else $error("status moved outside cycle start");
   chk_no_io_bits: assert property (
      t1_strobe |-> !status_byte[ST_IN] && !status_byte[ST_OUT])
      else $error("io status in sequencer cycle");
endmodule // ies_properties

// ### bench/cpu_interrupt_entry_sequencer_bench.sv
// self-checking bench joining both ends of the link
`timescale 1ns/100ps
module cpu_interrupt_entry_sequencer_bench
   import ies_pkg::*;
;
   logic        clock, arst_n, insn_last, irq_enable_insn, halted;
   logic        raise_req, hold_in, saw_halt;
   logic        seq_busy_ff, halted_ack_status_ff, req_pending_ff;
   logic [1:0]  wait_periods;
   logic [7:0]  insn_byte, ir_ff, b;
   logic [15:0] target_addr, pc_ff, sp_ff, exp_pc, exp_sp, pushed;
   int          fail_count, cmp_count, seed, n;

   always #20 clock = ~clock;

   ies_bus_if bus ();
   ies_cpu_end u_ies_cpu_end (.clock(clock), .arst_n(arst_n), .bus(bus),
      .insn_last(insn_last), .irq_enable_insn(irq_enable_insn),
      .halted(halted), .seq_busy_ff(seq_busy_ff), .pc_ff(pc_ff),
      .sp_ff(sp_ff), .ir_ff(ir_ff),
      .halted_ack_status_ff(halted_ack_status_ff));
   ies_ext_end u_ies_ext_end (.clock(clock), .arst_n(arst_n), .bus(bus),
      .raise_req(raise_req), .insn_byte(insn_byte),
      .target_addr(target_addr), .wait_periods(wait_periods),
      .hold_in(hold_in), .req_pending_ff(req_pending_ff));
   ies_properties u_ies_properties (.clock(clock), .arst_n(arst_n),
      .service_req(bus.service_req),
      .accept_enable_out(bus.accept_enable_out),
      .t1_strobe(bus.t1_strobe), .t3_strobe(bus.t3_strobe),
      .status_byte(bus.status_byte), .addr(bus.addr),
      .ready(bus.ready), .hold(bus.hold));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch %s exp %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   function automatic logic jumps(input logic [7:0] op);
      return op == OP_CALL || (op & VEC_MASK) == VEC_CODE;
   endfunction

   task automatic wait_busy(input logic lvl);
      int k;
      k = 0;
      while (seq_busy_ff !== lvl && k < 80)
      begin
         @(posedge clock);
         saw_halt = saw_halt | (halted_ack_status_ff === 1'b1);
         if (bus.t1_strobe === 1'b1 && bus.status_byte === 8'h00)
            pushed = {pushed[7:0], bus.data_from_cpu};
         k++;
      end
      if (seq_busy_ff !== lvl)
      begin
         fail_count++;
         wrap_up();
      end
   endtask

   // one inserted instruction: opcode, target, halted, hold
   task automatic serve(input logic [7:0] op, input logic [15:0] t,
                        input logic hlt, input logic hld);
      @(posedge clock);
      irq_enable_insn <= 1'b1;
      insn_byte <= op;
      target_addr <= t;
      wait_periods <= 2'($random(seed));
      halted <= hlt;
      hold_in <= hld;
      @(posedge clock);
      irq_enable_insn <= 1'b0;
      raise_req <= 1'b1;
      @(posedge clock);
      raise_req <= 1'b0;
      insn_last <= ~hlt;
      saw_halt = 1'b0;
      pushed = 16'h0000;
      if (hld)
      begin
         repeat (12) @(posedge clock);
         check("busy in hold", 16'(seq_busy_ff), 16'h0);
         hold_in <= 1'b0;
      end
      wait_busy(1'b1);
      insn_last <= 1'b0;
      wait_busy(1'b0);
      halted <= 1'b0;
      if (jumps(op))
         check("pushed pc", pushed, exp_pc);
      if (op == OP_CALL)
         exp_pc = t;
      else if (jumps(op))
         exp_pc = {10'h0, op[5:3], 3'h0};
      if (jumps(op))
         exp_sp = exp_sp - 16'h2;
      check("ir", 16'(ir_ff), 16'(op));
      check("pc", pc_ff, exp_pc);
      check("sp", sp_ff, exp_sp);
      check("halt ack", 16'(saw_halt), 16'(hlt));
      check("req dropped", 16'(req_pending_ff), 16'h0);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      clock = 1'b0;
      arst_n = 1'b0;
      {insn_last, irq_enable_insn, halted, raise_req, hold_in} = 5'h0;
      wait_periods = 2'h0;
      insn_byte = 8'h0;
      target_addr = 16'h0;
      seed = 32'h49fb20de;
      fail_count = 0;
      cmp_count = 0;
      exp_pc = PC_RESET;
      exp_sp = SP_RESET;
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      check("accept at reset", 16'(bus.accept_enable_out), 16'h0);
      for (n = 0; n < 8; n++)
         serve({2'b11, 3'(n), 3'b111}, 16'h0, 1'b0, 1'b0);
      serve(OP_CALL, 16'hffff, 1'b0, 1'b1);
      serve(8'h04, 16'h0, 1'b1, 1'b0);
      serve(OP_CALL, 16'h0100, 1'b1, 1'b0);
      for (n = 0; n < 24; n++)
      begin
         b = 8'($random(seed));
         if (b == OP_SWAP)
            b = OP_NOP;
         serve(b, 16'($random(seed)), 1'($random(seed)), 1'b0);
      end
      wrap_up();
   end
endmodule // cpu_interrupt_entry_sequencer_bench
